// >>> verilog/dpwa_arbiter.sv
// Purpose: Write arbiter in front of one core's L2 slave DMA port
// Assumes: Slave side accepts a command or data beat every cycle
// Notes:   fix_order_en selects the ordering-safe grant policy
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - This stage alone fronts one core's l2_slave_dma_port for all masters.
// - Two input paths; each grants only masters of its own fixed set.
// - A write's path follows solely from its issuing master's identity.
// - While the core is busy, writes on both paths are stalled.
// - On release, legacy grant may favour a later write on the other path.
// - Crossed second-write grants at two stalled slaves can hang both.
// - Such a hang needs two masters, two slaves, both cores stalling.
// - Write data is taken in the order commands were granted.
module dpwa_arbiter (
	// Clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         resetn,
	// Core state and policy
	input  wire logic                         core_busy,
	input  wire logic                         fix_order_en,
	// Path A command
	input  wire logic                         a_cmd_valid,
	output logic                              a_cmd_ready,
	input  wire logic [dpwa_pkg::MID_W-1:0]   a_cmd_mid,
	input  wire logic [dpwa_pkg::ADDR_W-1:0]  a_cmd_addr,
	input  wire logic                         a_older_pending,
	// Path A data
	input  wire logic                         a_wdata_valid,
	output logic                              a_wdata_ready,
	input  wire logic [dpwa_pkg::DATA_W-1:0]  a_wdata,
	input  wire logic                         a_wlast,
	// Path B command
	input  wire logic                         b_cmd_valid,
	output logic                              b_cmd_ready,
	input  wire logic [dpwa_pkg::MID_W-1:0]   b_cmd_mid,
	input  wire logic [dpwa_pkg::ADDR_W-1:0]  b_cmd_addr,
	input  wire logic                         b_older_pending,
	// Path B data
	input  wire logic                         b_wdata_valid,
	output logic                              b_wdata_ready,
	input  wire logic [dpwa_pkg::DATA_W-1:0]  b_wdata,
	input  wire logic                         b_wlast,
	// Slave port command
	output logic                              slv_cmd_valid_q,
	output logic [dpwa_pkg::ADDR_W-1:0]       slv_cmd_addr_q,
	output logic [dpwa_pkg::MID_W-1:0]        slv_cmd_mid_q,
	output logic                              slv_cmd_path_q,
	// Slave port data
	output logic                              slv_wr_valid_q,
	output logic [dpwa_pkg::DATA_W-1:0]       slv_wr_data_q,
	output logic                              slv_wr_last_q,
	// Status
	output logic                              path_err_q,
	output logic                              stalled
);
	import dpwa_pkg::*;

	// ==========================================================
	// Per-path views
	wire logic [1:0]        cmd_valid;
	wire logic [1:0]        older_pending;
	wire logic [1:0]        wdata_valid;
	wire logic [1:0]        wlast;
	wire logic [MID_W-1:0]  cmd_mid [2];
	wire logic [1:0]        path_of;
	wire logic [1:0]        member_ok;
	wire logic [1:0]        eligible;
	wire logic [1:0]        grant;
	wire logic [1:0]        foreign;
	wire logic [1:0]        wdata_ready;

	assign cmd_valid     = {b_cmd_valid, a_cmd_valid};
	assign older_pending = {b_older_pending, a_older_pending};
	assign wdata_valid   = {b_wdata_valid, a_wdata_valid};
	assign wlast         = {b_wlast, a_wlast};
	assign cmd_mid[0]    = a_cmd_mid;
	assign cmd_mid[1]    = b_cmd_mid;

	// ==========================================================
	// Grant order memory state
	logic                   ord_mem [ORD_DEPTH];
	logic [ORD_PTR_W-1:0]   wr_ptr_q;
	logic [ORD_PTR_W-1:0]   rd_ptr_q;
	logic [ORD_CNT_W-1:0]   ord_cnt_q;
	logic                   last_grant_q;
	dpwa_state_t            state_q;
	dpwa_state_t            state_d;

	wire logic ord_empty;
	wire logic ord_full;
	wire logic head_path;

	assign ord_empty = (ord_cnt_q == RST_CNT);
	assign ord_full  = (ord_cnt_q == ORD_FULL_CNT);
	assign head_path = ord_mem[rd_ptr_q];

	// ==========================================================
	// Path membership and eligibility
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_path
			dpwa_path_map u_map (
				.mid  (cmd_mid[p]),
				.path (path_of[p])
			);
			// Issuing master alone decides the path
			assign member_ok[p]   = (path_of[p] == 1'(p));
			assign foreign[p]     = cmd_valid[p] & ~member_ok[p];
			// Busy core holds off every path
			assign eligible[p]    = cmd_valid[p] & member_ok[p]
				& ~core_busy & ~ord_full
				& ~(fix_order_en & older_pending[p]);
			// Data only from the path at the head of grant order
			assign wdata_ready[p] = ~ord_empty & ~core_busy
				& (head_path == 1'(p));
		end
	endgenerate

	// ==========================================================
	// Arbitration: alternate away from the last granted path.
	// Without the safe policy this can pass a later write ahead
	// of an earlier one from another master on the other path.
	wire logic grant_b;
	assign grant_b  = eligible[1]
		& (~eligible[0] | (last_grant_q == PATH_A));
	assign grant[1] = grant_b;
	assign grant[0] = eligible[0] & ~grant_b;

	wire logic grant_any;
	assign grant_any = |grant;

	// Foreign masters are taken and dropped so the path keeps moving
	assign a_cmd_ready   = grant[0] | foreign[0];
	assign b_cmd_ready   = grant[1] | foreign[1];
	assign a_wdata_ready = wdata_ready[0];
	assign b_wdata_ready = wdata_ready[1];

	wire logic [1:0] data_fire;
	wire logic       data_any;
	wire logic       pop;
	assign data_fire = wdata_valid & wdata_ready;
	assign data_any  = |data_fire;
	assign pop       = |(data_fire & wlast);

	// ==========================================================
	// Grant order memory
	always_ff @(posedge core_clk) begin
		if (grant_any) begin
			ord_mem[wr_ptr_q] <= grant_b;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_q     <= RST_PTR;
			rd_ptr_q     <= RST_PTR;
			ord_cnt_q    <= RST_CNT;
			last_grant_q <= RST_LAST_GRANT;
		end else begin
			if (grant_any) begin
				wr_ptr_q     <= wr_ptr_q + 2'h1;
				last_grant_q <= grant_b;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 2'h1;
			end
			case ({grant_any, pop})
				2'b10:   ord_cnt_q <= ord_cnt_q + 3'h1;
				2'b01:   ord_cnt_q <= ord_cnt_q - 3'h1;
				default: ord_cnt_q <= ord_cnt_q;
			endcase
		end
	end

	// ==========================================================
	// Slave port outputs
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			slv_cmd_valid_q <= 1'b0;
			slv_cmd_addr_q  <= '0;
			slv_cmd_mid_q   <= '0;
			slv_cmd_path_q  <= PATH_A;
			slv_wr_valid_q  <= 1'b0;
			slv_wr_data_q   <= '0;
			slv_wr_last_q   <= 1'b0;
			path_err_q      <= 1'b0;
		end else begin
			slv_cmd_valid_q <= grant_any;
			if (grant_any) begin
				slv_cmd_addr_q <= grant_b ? b_cmd_addr : a_cmd_addr;
				slv_cmd_mid_q  <= grant_b ? b_cmd_mid : a_cmd_mid;
				slv_cmd_path_q <= grant_b;
			end
			slv_wr_valid_q <= data_any;
			if (data_any) begin
				slv_wr_data_q <= data_fire[1] ? b_wdata : a_wdata;
				slv_wr_last_q <= pop;
			end
			path_err_q <= |foreign;
		end
	end

	// ==========================================================
	// Activity state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE, ST_STALL, ST_SERVE: begin
				if (core_busy & ((|cmd_valid) | ~ord_empty)) begin
					state_d = ST_STALL;
				end else if (~ord_empty | grant_any) begin
					state_d = ST_SERVE;
				end else begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign stalled = (state_q == ST_STALL);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	a_busy_no_grant: assert property (
		core_busy |-> !(a_cmd_ready && member_ok[0])
			&& !(b_cmd_ready && member_ok[1]) && !a_wdata_ready
			&& !b_wdata_ready)
		else $error("command or data taken while core busy");

	a_grant_reaches_slave: assert property (
		(a_cmd_valid && a_cmd_ready && member_ok[0] && !grant_b)
		|=> slv_cmd_valid_q && !slv_cmd_path_q
			&& slv_cmd_addr_q == $past(a_cmd_addr))
		else $error("path A grant not presented at slave port");

	a_path_by_master: assert property (
		slv_cmd_valid_q |-> PATH_B_MEMBERS[slv_cmd_mid_q] == slv_cmd_path_q)
		else $error("write arrived on path of another master set");

	a_foreign_dropped: assert property (
		(b_cmd_valid && !member_ok[1]) |-> b_cmd_ready ##1
			(path_err_q && !(slv_cmd_valid_q && slv_cmd_path_q)))
		else $error("foreign master on path B not dropped and flagged");

	a_data_in_order: assert property (
		a_wdata_ready |-> !ord_empty && head_path == PATH_A
			&& !b_wdata_ready)
		else $error("data taken out of grant order");

	a_safe_block: assert property (
		(fix_order_en && b_older_pending && b_cmd_valid && member_ok[1])
		|=> !(slv_cmd_valid_q && slv_cmd_path_q))
		else $error("later write granted while older one waits");

	a_alternate_pref: assert property (
		(eligible == 2'b11 && last_grant_q == PATH_A) |-> grant_b
			##1 (last_grant_q == PATH_B && slv_cmd_path_q == PATH_B))
		else $error("arbiter did not alternate paths");

	a_stall_needs_busy: assert property (
		stalled |-> $past(core_busy))
		else $error("stall state without busy core");

	a_stall_entry: assert property (
		(core_busy && a_cmd_valid) |=> stalled [*1] ##0 !slv_cmd_valid_q)
		else $error("busy core with pending write not stalled");

	a_order_depth: assert property (
		ord_full |-> !grant_any ##1 ord_cnt_q <= ORD_FULL_CNT)
		else $error("grant order memory overflow");

	c_b_over_a: cover property (eligible == 2'b11 ##0 grant_b);
	c_stall_release: cover property (stalled ##1 !core_busy ##1 grant_any);
	c_safe_hold: cover property (fix_order_en && a_older_pending
		&& a_cmd_valid && member_ok[0]);
	c_two_outstanding: cover property (ord_cnt_q == 3'h2 ##[1:20] pop);
endmodule
`default_nettype wire

// >>> shared/dpwa_pkg.sv
// Purpose: Constants and types for the dual-path L2 write arbiter
// Assumes: One interconnect clock, one active-low asynchronous reset
// Notes:   Master membership of the two paths is a fixed table
package dpwa_pkg;
	// ==========================================================
	// Widths
	localparam int unsigned MID_W   = 4;
	localparam int unsigned ADDR_W  = 32;
	localparam int unsigned DATA_W  = 32;
	// ==========================================================
	// Path encoding and membership (bit set: master on path B)
	localparam logic              PATH_A          = 1'b0;
	localparam logic              PATH_B          = 1'b1;
	localparam logic [15:0]       PATH_B_MEMBERS  = 16'hFF00;
	// ==========================================================
	// Grant order memory
	localparam int unsigned       ORD_DEPTH       = 4;
	localparam int unsigned       ORD_PTR_W       = 2;
	localparam int unsigned       ORD_CNT_W       = 3;
	localparam logic [ORD_CNT_W-1:0] ORD_FULL_CNT = 3'h4;
	// ==========================================================
	// Reset values
	localparam logic              RST_LAST_GRANT  = PATH_B;
	localparam logic [ORD_PTR_W-1:0] RST_PTR      = 2'h0;
	localparam logic [ORD_CNT_W-1:0] RST_CNT      = 3'h0;
	// ==========================================================
	// Activity states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_STALL = 2'b01,
		ST_SERVE = 2'b11
	} dpwa_state_t;
endpackage

// >>> verilog/dpwa_path_map.sv
// Purpose: Maps a master identity to the input path it must use
// Assumes: Membership table is fixed at build time
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module dpwa_path_map (
	// Master identity in
	input  wire logic [dpwa_pkg::MID_W-1:0] mid,
	// Path of that master
	output logic                            path
);
	import dpwa_pkg::*;
	assign path = PATH_B_MEMBERS[mid];
endmodule
`default_nettype wire

// >>> tb/dpwa_master_model.sv
// Purpose: Behavioural write-data source standing for one device master
// Assumes: One burst in flight per model, started by a go pulse
// Notes:   Data line shows the inverse of its last value once released
`timescale 1ns/1ps
`default_nettype none
module dpwa_master_model #(
	parameter logic [31:0] BASE = 32'h0
) (
	// Clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        resetn,
	// Burst request from the bench
	input  wire logic                        go,
	input  wire logic [1:0]                  beats,
	// Data channel
	input  wire logic                        wdata_ready,
	output logic                             wdata_valid,
	output logic [dpwa_pkg::DATA_W-1:0]      wdata,
	output logic                             wlast
);
	import dpwa_pkg::*;
	logic [1:0] idx_q;
	logic       end_w;
	assign end_w = (idx_q == 2'(beats - 2'h1));
	assign wlast = wdata_valid && end_w;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wdata_valid <= 1'b0;
			idx_q <= 2'h0;
			wdata <= 32'h0;
		end else if (go && !wdata_valid) begin
			wdata_valid <= 1'b1;
			idx_q <= 2'h0;
			wdata <= BASE;
		end else if (wdata_valid && wdata_ready) begin
			if (end_w) begin
				wdata_valid <= 1'b0;
				wdata <= ~wdata;
			end else begin
				idx_q <= idx_q + 2'h1;
				wdata <= BASE + {30'h0, idx_q} + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/dpwa_arbiter_bench.sv
// Purpose: Self-checking bench for the dual-path write arbiter
// Assumes: Bench drives commands, two master models drive data
// Notes:   Random traffic from seed 60 plus ordering corner cases
`timescale 1ns/1ps
`default_nettype none
module dpwa_arbiter_bench;
	import dpwa_pkg::*;
	logic core_clk, resetn, core_busy, fix_order_en, stalled, path_err_q;
	logic a_cmd_valid, a_cmd_ready, a_older_pending, a_wdata_valid;
	logic b_cmd_valid, b_cmd_ready, b_older_pending, b_wdata_valid;
	logic a_wdata_ready, a_wlast, b_wdata_ready, b_wlast, a_go, b_go;
	logic slv_cmd_valid_q, slv_cmd_path_q, slv_wr_valid_q, slv_wr_last_q;
	logic [MID_W-1:0]  a_cmd_mid, b_cmd_mid, slv_cmd_mid_q;
	logic [ADDR_W-1:0] a_cmd_addr, b_cmd_addr, slv_cmd_addr_q;
	logic [DATA_W-1:0] a_wdata, b_wdata, slv_wr_data_q;
	logic [1:0]        a_beats, b_beats, nb;
	logic [31:0]       seen[$], exp[$];
	logic              gq[$], p, lseen[$], lexp[$];
	int                n_fail, n_compared;
	dpwa_arbiter uut (.*);
	dpwa_master_model #(.BASE(32'hA0000000)) ma (.core_clk(core_clk),
		.resetn(resetn), .go(a_go), .beats(a_beats),
		.wdata_ready(a_wdata_ready), .wdata_valid(a_wdata_valid),
		.wdata(a_wdata), .wlast(a_wlast));
	dpwa_master_model #(.BASE(32'hB0000000)) mb (.core_clk(core_clk),
		.resetn(resetn), .go(b_go), .beats(b_beats),
		.wdata_ready(b_wdata_ready), .wdata_valid(b_wdata_valid),
		.wdata(b_wdata), .wlast(b_wlast));
	function automatic logic [31:0] beat(input logic q, input int i);
		return (q ? 32'hB0000000 : 32'hA0000000) + 32'(i);
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		$display("fails=%0d compares=%0d", n_fail, n_compared);
		if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Request one command; ok low means a foreign master to be dropped
	task automatic cmd(input logic q, input logic [3:0] m,
			input logic [31:0] ad, input logic ok);
		int n;
		@(posedge core_clk);
		if (q) begin
			b_cmd_valid <= 1'b1; b_cmd_mid <= m; b_cmd_addr <= ad;
		end else begin
			a_cmd_valid <= 1'b1; a_cmd_mid <= m; a_cmd_addr <= ad;
		end
		n = 0;
		do begin @(posedge core_clk); n++; end
		while ((q ? b_cmd_ready : a_cmd_ready) !== 1'b1 && n < 60);
		if (q) b_cmd_valid <= 1'b0;
		else a_cmd_valid <= 1'b0;
		#1;
		chk(n < 60, 1);
		chk(slv_cmd_valid_q, ok);
		chk(path_err_q, !ok);
		if (ok) begin
			chk(slv_cmd_path_q, q);
			chk(slv_cmd_addr_q, ad);
			chk(slv_cmd_mid_q, m);
		end
	endtask
	task automatic send(input logic q, input logic [1:0] k);
		int n;
		@(posedge core_clk);
		if (q) begin b_beats <= k; b_go <= 1'b1; end
		else begin a_beats <= k; a_go <= 1'b1; end
		@(posedge core_clk);
		if (q) b_go <= 1'b0;
		else a_go <= 1'b0;
		n = 0;
		do begin @(posedge core_clk); n++; end
		while ((q ? b_wdata_valid : a_wdata_valid) !== 1'b0 && n < 100);
		chk(n < 100, 1);
		for (int i = 0; i < k; i++) begin
			exp.push_back(beat(q, i));
			lexp.push_back(i == k - 1);
		end
	endtask
	task automatic flush;
		repeat (3) @(posedge core_clk);
		chk(seen.size(), exp.size());
		foreach (exp[i]) if (i < seen.size()) chk(seen[i], exp[i]);
		foreach (lexp[i]) if (i < lseen.size()) chk(lseen[i], lexp[i]);
		seen.delete();
		exp.delete();
		lseen.delete();
		lexp.delete();
	endtask
	always @(posedge core_clk) begin
		if (slv_wr_valid_q === 1'b1) begin
			seen.push_back(slv_wr_data_q);
			lseen.push_back(slv_wr_last_q);
		end
		if (slv_cmd_valid_q === 1'b1) gq.push_back(slv_cmd_path_q);
	end
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		wrap_up;
	end
	initial begin
		{resetn, core_busy, fix_order_en, a_cmd_valid, b_cmd_valid} = '0;
		{a_older_pending, b_older_pending, a_go, b_go} = '0;
		{a_cmd_mid, b_cmd_mid, a_cmd_addr, b_cmd_addr} = '0;
		{a_beats, b_beats} = '0;
		n_fail = 0;
		n_compared = 0;
		void'($urandom(60));
		repeat (3) @(posedge core_clk);
		chk({slv_cmd_valid_q, slv_wr_valid_q, path_err_q, stalled}, 0);
		resetn <= 1'b1;
		// Second burst must wait for the first granted one
		cmd(0, 4'h7, 32'h1000, 1);
		cmd(1, 4'h8, 32'h2000, 1);
		fork
			send(1, 2'h2);
			begin
				repeat (4) @(posedge core_clk);
				chk(b_wdata_ready, 0);
				chk(slv_wr_valid_q, 0);
				send(0, 2'h1);
			end
		join
		flush;
		// Busy core stalls both paths, release grants alternately
		gq.delete();
		@(posedge core_clk);
		core_busy <= 1'b1;
		fork
			cmd(0, 4'h0, 32'hC0, 1);
			cmd(1, 4'hF, 32'hD0, 1);
			begin
				repeat (3) @(posedge core_clk);
				chk(a_cmd_ready, 0);
				chk(b_cmd_ready, 0);
				chk(stalled, 1);
				core_busy <= 1'b0;
			end
		join
		// Monitor records the second grant in gq one edge after the task returns
		@(posedge core_clk);
		#1;
		chk(gq.size() > 1 ? {gq[0], gq[1]} : 2'h3, {PATH_A, PATH_B});
		send(0, 2'h3);
		send(1, 2'h1);
		flush;
		// Foreign masters are dropped on either path
		cmd(0, 4'h8, 32'h10, 0);
		cmd(1, 4'h7, 32'h14, 0);
		// Safe policy holds a master with an older ungranted write
		@(posedge core_clk);
		fix_order_en <= 1'b1;
		a_older_pending <= 1'b1;
		b_older_pending <= 1'b1;
		fork
			cmd(0, 4'h3, 32'h44, 1);
			cmd(1, 4'h9, 32'h40, 1);
			begin
				repeat (3) @(posedge core_clk);
				chk(a_cmd_ready, 0);
				chk(b_cmd_ready, 0);
				a_older_pending <= 1'b0;
				b_older_pending <= 1'b0;
			end
		join
		// Last grant was path B, so path A is granted first here
		send(0, 2'h1);
		send(1, 2'h2);
		flush;
		fix_order_en <= 1'b0;
		// Random traffic, legacy policy ignores older writes
		repeat (16) begin
			p = 1'($urandom_range(0, 1));
			nb = 2'($urandom_range(1, 3));
			a_older_pending <= 1'($urandom_range(0, 1));
			cmd(p, 4'($urandom_range(0, 7)) | {p, 3'h0}, $urandom, 1);
			send(p, nb);
			flush;
		end
		wrap_up;
	end
endmodule
`default_nettype wire
